// ==== test/icnd_host_model.sv ====
// Host controller model driving the direct input lines
`timescale 1ns/1ps
module icnd_host_model
	import icnd_pkg::*;
(
	input  wire logic                 mclk_i,
	output logic      [ICND_NDIN-1:0] din_o
);
	initial din_o = '0;

	// ==========================================================
	// Line driver: change just after an edge, then hold
	task automatic set_line(input int n, input logic v);
		@(posedge mclk_i);
		din_o[n] <= v;
	endtask : set_line
endmodule : icnd_host_model

// ==== test/testbench.sv ====
// Self-checking testbench of the input conditioning block
`timescale 1ns/1ps
module testbench
	import icnd_pkg::*;
;
	localparam int MS = 20;
	localparam int OS = 10;
	logic                 mclk_i = 1'b0;
	logic                 rst_i  = 1'b1;
	logic                 single_pulse_mode_i = 1'b0;
	logic [ICND_NFN-1:0]  out_sig_i = '0;
	logic [7:0]           reg_addr_i = 8'h00;
	logic [31:0]          reg_wdata_i = 32'h0;
	logic                 reg_wr_i = 1'b0;
	logic                 reg_rd_i = 1'b0;
	logic [ICND_NDIN-1:0] din;
	logic [31:0]          rdata, p_rdata;
	logic [ICND_NFN-1:0]  func;
	logic                 cwp, p_cwp, p_spp;
	int                   n_mismatch = 0;
	int                   total_checks = 0;
	int                   n;
	logic [31:0]          d, pd;
	int                   fn_def [10] = '{32, 64, 65, 66, 37, 1, 5, 8, 48, 49};

	always #2.5 mclk_i = ~mclk_i;

	icnd_host_model host_u (.mclk_i(mclk_i), .din_o(din));

	icnd_top #(.PULSE_VARIANT(1'b0), .MS_CYCLES(MS), .ONESHOT_CYCLES(OS)) dut_u (
		.mclk_i(mclk_i), .rst_i(rst_i), .din_i(din), .single_pulse_mode_i(single_pulse_mode_i),
		.out_sig_i(out_sig_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .func_o(func),
		.clockwise_pulse_pos_o(cwp), .clockwise_pulse_neg_o(), .counterclockwise_pulse_pos_o(),
		.counterclockwise_pulse_neg_o(), .single_pulse_pos_o(), .single_pulse_neg_o(),
		.pulse_direction_pos_o(), .pulse_direction_neg_o());

	icnd_top #(.PULSE_VARIANT(1'b1), .MS_CYCLES(MS), .ONESHOT_CYCLES(OS)) dut_p (
		.mclk_i(mclk_i), .rst_i(rst_i), .din_i(din), .single_pulse_mode_i(single_pulse_mode_i),
		.out_sig_i(out_sig_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(p_rdata), .func_o(),
		.clockwise_pulse_pos_o(p_cwp), .clockwise_pulse_neg_o(),
		.counterclockwise_pulse_pos_o(), .counterclockwise_pulse_neg_o(),
		.single_pulse_pos_o(p_spp), .single_pulse_neg_o(), .pulse_direction_pos_o(),
		.pulse_direction_neg_o());

	// ==========================================================
	// Bus and compare tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [31:0] pv);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i   <= 1'b0;
		#1;
		v  = rdata;
		pv = p_rdata;
	endtask : rd

	// Counts edges until a function bit reaches a level, bounded
	task automatic wait_fn(input int idx, input logic v, output int cnt);
		cnt = 0;
		while (func[idx] !== v && cnt < 400) begin
			@(posedge mclk_i);
			#1;
			cnt++;
		end
	endtask : wait_fn

	task automatic in_range(input int v, input int lo, input int hi);
		chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
	endtask : in_range

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	initial begin
		#(20000 * 5);
		n_mismatch++;
		end_sim();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (int c = 0; c < 14; c++) begin
			rd(ICND_FN_BASE + 8'(c), d, pd);
			chk(d, (c < 10) ? 32'(fn_def[c]) : 32'h0);
			if (c < 4)
				chk(pd, 32'h0);
			rd(ICND_CTL_BASE + 8'(c), d, pd);
			chk(d, 32'h0);
		end
		for (int c = 0; c < 10; c++) begin
			rd(ICND_COMP_BASE + 8'(c), d, pd);
			chk(d, 32'h0);
		end
		for (int v = 0; v < 4; v++) begin
			rd(ICND_SRC_BASE + 8'(v), d, pd);
			chk(d, 32'h80);
		end
		rd(8'h7f, d, pd);
		chk(d, 32'h0);
		wr(ICND_FN_BASE, 32'h21);
		rd(ICND_FN_BASE, d, pd);
		chk(d, 32'h21);
		chk(pd, 32'h0);
		$display("test defaults done");

		wr(ICND_COMP_BASE + 8'h04, 32'h50);
		host_u.set_line(4, 1'b1);
		wait_fn(37, 1'b1, n);
		chk(32'(n), 32'h4);
		chk({31'h0, func[8'h50]}, 32'h1);
		rd(ICND_STAT, d, pd);
		chk({31'h0, d[4]}, 32'h1);
		host_u.set_line(4, 1'b0);
		wr(ICND_CTL_BASE + 8'h05, 32'h1);
		wait_fn(1, 1'b1, n);
		in_range(n, 1, 8);
		$display("test routing done");

		wr(ICND_CTL_BASE + 8'h08, 32'hff00);
		rd(ICND_CTL_BASE + 8'h08, d, pd);
		chk(d, 32'hfa00);
		wr(ICND_CTL_BASE + 8'h06, 32'h0200);
		host_u.set_line(6, 1'b1);
		wait_fn(5, 1'b1, n);
		in_range(n, 2 * MS, 3 * MS + 4);
		$display("test dead-time done");

		// One-shot only on a line with a momentary function
		wr(ICND_CTL_BASE + 8'h07, 32'h2);
		host_u.set_line(7, 1'b1);
		wait_fn(8, 1'b1, n);
		chk(32'(n), 32'h4);
		wait_fn(8, 1'b0, n);
		in_range(n, OS, OS + 1);
		repeat (30) @(posedge mclk_i);
		chk({31'h0, func[8]}, 32'h0);
		$display("test one-shot done");

		wr(ICND_FN_BASE + 8'd10, 32'h60);
		wr(ICND_SRC_BASE, 32'h07);
		@(posedge mclk_i);
		out_sig_i[7] <= 1'b1;
		wait_fn(8'h60, 1'b1, n);
		chk(32'(n), 32'h2);
		wr(ICND_FN_BASE + 8'd11, 32'h61);
		wr(ICND_CTL_BASE + 8'd11, 32'h1);
		wait_fn(8'h61, 1'b1, n);
		in_range(n, 0, 6);
		wr(ICND_FN_BASE + 8'd12, 32'h62);
		wr(ICND_SRC_BASE + 8'h02, 32'h09);
		wr(ICND_CTL_BASE + 8'd12, 32'h0102);
		@(posedge mclk_i);
		out_sig_i[9] <= 1'b1;
		wait_fn(8'h62, 1'b1, n);
		in_range(n, MS, 2 * MS + 2);
		wait_fn(8'h62, 1'b0, n);
		in_range(n, OS, OS + 1);
		$display("test virtual done");

		host_u.set_line(0, 1'b1);
		repeat (6) @(posedge mclk_i);
		chk({31'h0, p_cwp}, 32'h1);
		chk({31'h0, cwp}, 32'h0);
		single_pulse_mode_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		chk({30'h0, p_spp, p_cwp}, 32'h2);
		$display("test pulse done");
		end_sim();
	end
endmodule : testbench

// ==== verilog/icnd_chan_if.sv ====
// Link between the top module and one channel conditioner
`timescale 1ns/1ps
interface icnd_chan_if;
	logic       raw;
	logic       inv;
	logic       os_en;
	logic       tick;
	logic [7:0] dead;
	logic       on;

	modport filt (input raw, input inv, input os_en, input tick, input dead, output on);
	modport feed (output raw, output inv, output os_en, output tick, output dead, input on);
endinterface : icnd_chan_if

// ==== verilog/icnd_cond.sv ====
// One channel conditioner: inversion, ON dead-time, one-shot
`timescale 1ns/1ps
module icnd_cond
	import icnd_pkg::*;
#(
	parameter int ONESHOT_CYCLES = ICND_ONESHOT_CYC
) (
	input wire logic  mclk_i,
	input wire logic  rst_i,
	icnd_chan_if.filt ch
);
	localparam int OW = $clog2(ONESHOT_CYCLES + 1);
	localparam logic [OW-1:0] OS_LAST = OW'(ONESHOT_CYCLES - 1);

	icnd_st_e      st_q;
	icnd_st_e      st_d;
	logic [8:0]    cnt_q;
	logic [OW-1:0] os_q;
	logic          lvl;

	// ==========================================================
	// State
	assign lvl = ch.raw ^ ch.inv;

	always_comb begin
		st_d = st_q;
		case (st_q)
			ICND_OFF: if (lvl) begin
				st_d = (ch.dead == 8'h00) ? ICND_ON : ICND_QUAL;
			end
			ICND_QUAL: if (!lvl) begin
				st_d = ICND_OFF;
			end else if (ch.tick && cnt_q >= {1'b0, ch.dead}) begin
				st_d = ICND_ON;
			end
			ICND_ON: if (!lvl) begin
				st_d = ICND_OFF;
			end else if (ch.os_en && os_q == OS_LAST) begin
				st_d = ICND_SPENT;
			end
			ICND_SPENT: if (!lvl) begin
				st_d = ICND_OFF;
			end
			default: st_d = ICND_OFF;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) st_q <= ICND_OFF;
		else st_q <= st_d;
	end

	// Dead-time: whole ms ticks seen while held
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) cnt_q <= 9'h000;
		else if (st_q != ICND_QUAL) cnt_q <= 9'h000;
		else if (ch.tick) cnt_q <= cnt_q + 9'h001;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) os_q <= '0;
		else if (st_q != ICND_ON) os_q <= '0;
		else if (os_q != OS_LAST) os_q <= os_q + OW'(1);
	end

	assign ch.on = (st_q == ICND_ON);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_off_drop: assert property (!lvl |=> st_q != ICND_ON)
		else $error("Channel stayed on with input off");
	a_zero_dead: assert property (st_q == ICND_OFF && lvl && ch.dead == 8'h00
		|=> st_q == ICND_ON)
		else $error("Zero dead-time did not pass at once");
	a_qual_hold: assert property (st_q == ICND_QUAL && lvl && !(ch.tick
		&& cnt_q >= {1'b0, ch.dead}) |=> st_q == ICND_QUAL)
		else $error("Channel went on before dead-time");
	a_os_end: assert property (st_q == ICND_ON && lvl && ch.os_en && os_q == OS_LAST
		|=> st_q == ICND_SPENT ##1 !ch.on)
		else $error("One-shot did not end");
	a_os_off: assert property (st_q == ICND_ON && lvl && !ch.os_en
		|=> st_q == ICND_ON)
		else $error("Level input dropped without one-shot");
	c_spent: cover property (st_q == ICND_ON ##1 st_q == ICND_SPENT);
	c_qual_on: cover property (st_q == ICND_QUAL ##1 st_q == ICND_ON);

endmodule : icnd_cond

// ==== verilog/icnd_pkg.sv ====
// Constants, reset values and types of the input conditioning block
package icnd_pkg;

	// ==========================================================
	// Sizes
	localparam int ICND_NDIN = 10;
	localparam int ICND_NVIR = 4;
	localparam int ICND_NCH  = 14;
	localparam int ICND_NFN  = 256;

	// ==========================================================
	// Timing
	localparam int ICND_CLK_KHZ     = 200000;
	localparam int ICND_MS_CYC      = ICND_CLK_KHZ;
	localparam int ICND_ONESHOT_US  = 250;
	localparam int ICND_ONESHOT_CYC = ICND_ONESHOT_US * ICND_CLK_KHZ / 1000;
	localparam logic [7:0] ICND_DEAD_MAX_MS = 8'hfa;

	// ==========================================================
	// Register indices
	localparam logic [7:0] ICND_FN_BASE   = 8'h00;
	localparam logic [7:0] ICND_COMP_BASE = 8'h10;
	localparam logic [7:0] ICND_CTL_BASE  = 8'h20;
	localparam logic [7:0] ICND_SRC_BASE  = 8'h30;
	localparam logic [7:0] ICND_STAT      = 8'h40;
	localparam logic [7:0] ICND_RAW       = 8'h41;

	// Control word fields
	localparam int ICND_CTL_INV  = 0;
	localparam int ICND_CTL_OS   = 1;
	localparam int ICND_CTL_DEAD = 8;

	// ==========================================================
	// Reset values
	localparam logic [9:0][7:0] ICND_DIN_FN_RST = {8'h31, 8'h30, 8'h08, 8'h05, 8'h01,
		8'h25, 8'h42, 8'h41, 8'h40, 8'h20};
	localparam logic [7:0] ICND_FN_UNUSED = 8'h00;
	localparam logic [7:0] ICND_CONST_OFF = 8'h80;

	// ==========================================================
	// Conditioner states
	typedef enum logic [1:0] {
		ICND_OFF   = 2'b00,
		ICND_QUAL  = 2'b01,
		ICND_ON    = 2'b11,
		ICND_SPENT = 2'b10
	} icnd_st_e;

endpackage : icnd_pkg

// ==== verilog/icnd_top.sv ====
// Input signal conditioning and function routing
//
// Function
// - Ten direct lines, each with a function code; defaults include 32, 37, 49.
// - Pulse variant: lines 0 to 3 carry pulse input only, no function.
// - Pulse variant: lines default to clockwise/counter-clockwise legs, or pulse/direction.
// - Each direct line has inversion, 0 pass, 1 invert, default 0.
// - Each direct line has an ON dead-time of 0 to 250 ms.
// - A line counts as ON only once held longer than its dead-time.
// - One-shot enabled: recognised signal falls back after 250 us.
// - Each direct line has a composite function code, 0 unused.
// - Four virtual inputs, each with a function code, 0 unused.
// - Each virtual input selects its source by output code, default 128.
// - The virtual input's raw level follows its selected source, except for source code 128, which holds that level low ahead of inversion.
// - Each virtual input has inversion, 0 pass, 1 invert, default 0.
// - Each virtual input has an ON dead-time of 0 to 250 ms.
// - Each virtual input has a one-shot enable, default off.
`timescale 1ns/1ps
module icnd_top
	import icnd_pkg::*;
#(
	parameter bit PULSE_VARIANT  = 1'b0,
	parameter int MS_CYCLES      = ICND_MS_CYC,
	parameter int ONESHOT_CYCLES = ICND_ONESHOT_CYC
) (
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire logic [ICND_NDIN-1:0] din_i,
	input  wire logic                single_pulse_mode_i,
	input  wire logic [ICND_NFN-1:0] out_sig_i,
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [31:0]         reg_rdata_o,
	output logic      [ICND_NFN-1:0] func_o,
	output logic                     clockwise_pulse_pos_o,
	output logic                     clockwise_pulse_neg_o,
	output logic                     counterclockwise_pulse_pos_o,
	output logic                     counterclockwise_pulse_neg_o,
	output logic                     single_pulse_pos_o,
	output logic                     single_pulse_neg_o,
	output logic                     pulse_direction_pos_o,
	output logic                     pulse_direction_neg_o
);
	localparam int MW = $clog2(MS_CYCLES);
	localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);

	// ==========================================================
	// Helpers

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] n);
		return (a >= base) && (a < base + n);
	endfunction : hit

	function automatic logic [7:0] dead_clamp(input logic [7:0] v);
		return (v > ICND_DEAD_MAX_MS) ? ICND_DEAD_MAX_MS : v;
	endfunction : dead_clamp

	function automatic logic locked(input int ch);
		return PULSE_VARIANT && (ch < 4);
	endfunction : locked

	// ==========================================================
	// Storage

	logic [ICND_NDIN-1:0] din_s1_q;
	logic [ICND_NDIN-1:0] din_s2_q;
	logic                 mode_s1_q;
	logic                 mode_s2_q;
	logic [ICND_NCH-1:0][7:0] fn_q;
	logic [ICND_NDIN-1:0][7:0] comp_q;
	logic [ICND_NVIR-1:0][7:0] src_q;
	logic [ICND_NCH-1:0][7:0] dead_q;
	logic [ICND_NCH-1:0]  inv_q;
	logic [ICND_NCH-1:0]  os_q;
	logic [MW-1:0]        ms_cnt_q;
	logic                 tick_q;
	logic [ICND_NVIR-1:0] vraw_w;
	logic [ICND_NCH-1:0]  raw_w;
	logic [ICND_NCH-1:0]  on_w;
	logic [ICND_NFN-1:0]  func_d;
	logic [31:0]          rdata_d;
	logic [3:0]           idx;

	assign idx = reg_addr_i[3:0];

	// ==========================================================
	// Pin synchronisers

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			din_s1_q  <= '0;
			din_s2_q  <= '0;
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
		end else begin
			din_s1_q  <= din_i;
			din_s2_q  <= din_s1_q;
			mode_s1_q <= single_pulse_mode_i;
			mode_s2_q <= mode_s1_q;
		end
	end

	// ==========================================================
	// Millisecond tick

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ms_cnt_q <= '0;
			tick_q   <= 1'b0;
		end else begin
			ms_cnt_q <= (ms_cnt_q == MS_LAST) ? '0 : ms_cnt_q + MW'(1);
			tick_q   <= (ms_cnt_q == MS_LAST);
		end
	end

	// ==========================================================
	// Function codes

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < ICND_NCH; i++) begin
				if (i < ICND_NDIN && !locked(i)) fn_q[i] <= ICND_DIN_FN_RST[i];
				else fn_q[i] <= ICND_FN_UNUSED;
			end
		end else if (reg_wr_i && hit(reg_addr_i, ICND_FN_BASE, 8'(ICND_NCH))) begin
			if (!locked(int'(idx))) fn_q[idx] <= reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			comp_q <= '0;
		end else if (reg_wr_i && hit(reg_addr_i, ICND_COMP_BASE, 8'(ICND_NDIN))) begin
			if (!locked(int'(idx))) comp_q[idx] <= reg_wdata_i[7:0];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < ICND_NVIR; i++) src_q[i] <= ICND_CONST_OFF;
		end else if (reg_wr_i && hit(reg_addr_i, ICND_SRC_BASE, 8'(ICND_NVIR))) begin
			src_q[idx[1:0]] <= reg_wdata_i[7:0];
		end
	end

	// ==========================================================
	// Per-channel conditioning controls

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			inv_q  <= '0;
			os_q   <= '0;
			dead_q <= '0;
		end else if (reg_wr_i && hit(reg_addr_i, ICND_CTL_BASE, 8'(ICND_NCH))) begin
			inv_q[idx]  <= reg_wdata_i[ICND_CTL_INV];
			os_q[idx]   <= reg_wdata_i[ICND_CTL_OS];
			dead_q[idx] <= dead_clamp(reg_wdata_i[ICND_CTL_DEAD +: 8]);
		end
	end

	// ==========================================================
	// Virtual sources and channel raw levels

	always_comb begin
		for (int v = 0; v < ICND_NVIR; v++) begin
			vraw_w[v] = out_sig_i[src_q[v]] && (src_q[v] != ICND_CONST_OFF);
		end
	end

	assign raw_w = {vraw_w, din_s2_q};

	generate
		for (genvar g = 0; g < ICND_NCH; g++) begin : g_ch
			icnd_chan_if u_if ();

			assign u_if.raw   = raw_w[g];
			assign u_if.inv   = inv_q[g];
			assign u_if.os_en = os_q[g];
			assign u_if.dead  = dead_q[g];
			assign u_if.tick  = tick_q;
			assign on_w[g]    = u_if.on;

			icnd_cond #(
				.ONESHOT_CYCLES(ONESHOT_CYCLES)
			) u_cond (
				.mclk_i(mclk_i),
				.rst_i (rst_i),
				.ch    (u_if.filt)
			);
		end
	endgenerate

	// ==========================================================
	// Function routing

	always_comb begin
		func_d = '0;
		for (int i = 0; i < ICND_NCH; i++) begin
			if (on_w[i] && !locked(i)) begin
				func_d[fn_q[i]] = 1'b1;
				if (i < ICND_NDIN) func_d[comp_q[i]] = 1'b1;
			end
		end
		func_d[ICND_FN_UNUSED] = 1'b0;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) func_o <= '0;
		else func_o <= func_d;
	end

	// ==========================================================
	// Pulse legs

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			clockwise_pulse_pos_o        <= 1'b0;
			clockwise_pulse_neg_o        <= 1'b0;
			counterclockwise_pulse_pos_o <= 1'b0;
			counterclockwise_pulse_neg_o <= 1'b0;
			single_pulse_pos_o           <= 1'b0;
			single_pulse_neg_o           <= 1'b0;
			pulse_direction_pos_o        <= 1'b0;
			pulse_direction_neg_o        <= 1'b0;
		end else begin
			clockwise_pulse_pos_o        <= PULSE_VARIANT && !mode_s2_q && din_s2_q[0];
			clockwise_pulse_neg_o        <= PULSE_VARIANT && !mode_s2_q && din_s2_q[1];
			counterclockwise_pulse_pos_o <= PULSE_VARIANT && !mode_s2_q && din_s2_q[2];
			counterclockwise_pulse_neg_o <= PULSE_VARIANT && !mode_s2_q && din_s2_q[3];
			single_pulse_pos_o           <= PULSE_VARIANT && mode_s2_q && din_s2_q[0];
			single_pulse_neg_o           <= PULSE_VARIANT && mode_s2_q && din_s2_q[1];
			pulse_direction_pos_o        <= PULSE_VARIANT && mode_s2_q && din_s2_q[2];
			pulse_direction_neg_o        <= PULSE_VARIANT && mode_s2_q && din_s2_q[3];
		end
	end

	// ==========================================================
	// Register read

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit(reg_addr_i, ICND_FN_BASE, 8'(ICND_NCH))) begin
			rdata_d[7:0] = fn_q[idx];
		end else if (hit(reg_addr_i, ICND_COMP_BASE, 8'(ICND_NDIN))) begin
			rdata_d[7:0] = comp_q[idx];
		end else if (hit(reg_addr_i, ICND_CTL_BASE, 8'(ICND_NCH))) begin
			rdata_d[ICND_CTL_INV]       = inv_q[idx];
			rdata_d[ICND_CTL_OS]        = os_q[idx];
			rdata_d[ICND_CTL_DEAD +: 8] = dead_q[idx];
		end else if (hit(reg_addr_i, ICND_SRC_BASE, 8'(ICND_NVIR))) begin
			rdata_d[7:0] = src_q[idx[1:0]];
		end else if (reg_addr_i == ICND_STAT) begin
			rdata_d[ICND_NCH-1:0] = on_w;
		end else if (reg_addr_i == ICND_RAW) begin
			rdata_d[ICND_NCH-1:0] = raw_w;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) reg_rdata_o <= 32'h0000_0000;
		else if (reg_rd_i) reg_rdata_o <= rdata_d;
		else reg_rdata_o <= 32'h0000_0000;
	end

	// ==========================================================
	// Checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_primary_route: assert property (on_w[7] && fn_q[7] != ICND_FN_UNUSED
		|=> func_o[$past(fn_q[7])])
		else $error("Primary function not driven");
	a_comp_route: assert property (on_w[4] && comp_q[4] != ICND_FN_UNUSED
		&& fn_q[4] != ICND_FN_UNUSED
		|=> func_o[$past(comp_q[4])] && func_o[$past(fn_q[4])])
		else $error("Composite function not driven with primary");
	a_pulse_lock: assert property (PULSE_VARIANT |-> fn_q[0] == ICND_FN_UNUSED
		&& fn_q[3] == ICND_FN_UNUSED)
		else $error("Pulse line carries a function");
	a_const_off: assert property (src_q[0] == ICND_CONST_OFF && !inv_q[10]
		|=> !on_w[10])
		else $error("Constant-off source turned virtual input on");
	a_vir_on: assert property (raw_w[10] && !inv_q[10] && dead_q[10] == 8'h00
		&& !os_q[10] ##1 raw_w[10] |-> on_w[10])
		else $error("Virtual input not on with its source");
	a_dead_max: assert property (dead_q[13] <= ICND_DEAD_MAX_MS)
		else $error("Dead-time beyond maximum");
	a_unused_fn: assert property (!func_o[ICND_FN_UNUSED])
		else $error("Unused code driven");
	c_comp: cover property (func_o[comp_q[4]] && comp_q[4] != ICND_FN_UNUSED);
	c_vir: cover property (on_w[12] && src_q[2] != ICND_CONST_OFF);

endmodule : icnd_top
